// ---- include/emifc_pkg.sv ----
// Constants and types of the multiplexed external memory interface
// Behaviour
// - Interface owns its pins only while an off-chip external move runs.
// - During a move, drivers of pins acting as inputs are switched off.
// - Push-pull or open-drain mode of pins is never changed here.
// - Low address byte shares pins with data; high byte has own port.
// - Short-address moves take the high address byte from the page register, or from the high port latch with route 01.
// - Configuration bits 7:5 read zero; writes to them are ignored.
// - Configuration bit 4 reads zero; software must write zero.
// - Configuration holds route select in bits 3:2, pulse width in 1:0.
// - Route 00 on-chip, 01/10 split at 2 kB, 11 all off-chip.
// - Latch strobe high and low times are 1 to 4 clock cycles.
// - Address phase with latch strobe high, then data phase with strobe.
package emifc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  PAGE_SEL_ADDR  = 8'haa;
    localparam logic [7:0]  CFG_ADDR       = 8'hb2;
    localparam logic [7:0]  PAGE_RESET     = 8'h00;
    localparam logic [3:0]  CFG_RESET      = 4'h3;
    localparam int          ROUTE_LSB      = 2;
    localparam int          PULSE_LSB      = 0;

    // ------------------------------------------------------------------
    // Timing and address space
    // ------------------------------------------------------------------
    localparam logic [15:0] ONCHIP_LIMIT   = 16'h0800;
    localparam logic [2:0]  STROBE_CYCLES  = 3'h2;

    typedef enum logic [1:0] {
        ROUTE_INTERNAL    = 2'b00,
        ROUTE_SPLIT_LATCH = 2'b01,
        ROUTE_SPLIT_PAGE  = 2'b10,
        ROUTE_EXTERNAL    = 2'b11
    } emifc_route_t;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_ADDR   = 4'b0010,
        ST_LATCH  = 4'b0100,
        ST_STROBE = 4'b1000
    } emifc_state_t;

endpackage

// ---- logic/emifc_phase_timer.sv ----
// Down counter that times each phase of an external access
`timescale 1ns/100ps
`default_nettype none
module emifc_phase_timer (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Control
    input  wire logic       load,
    input  wire logic [2:0] load_val,
    // Status
    output logic            expired
);

    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (load) begin
            cnt_next = load_val;
        end else if (cnt_reg != 3'h0) begin
            cnt_next = cnt_reg - 3'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 3'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign expired = (cnt_reg == 3'h0);

endmodule
`default_nettype wire

// ---- logic/emifc_top.sv ----
// External memory interface: registers, routing and multiplexed bus engine
`timescale 1ns/100ps
`default_nettype none
module emifc_top (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Special function register port
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    // External move request from the core
    input  wire logic        req_valid,
    input  wire logic        req_write,
    input  wire logic        req_short,
    input  wire logic [15:0] req_addr,
    input  wire logic [7:0]  req_wdata,
    output logic             busy,
    output logic             done,
    output logic      [7:0]  rdata,
    // On-chip memory select
    output logic             int_access,
    output logic      [10:0] int_addr,
    // Port latch levels that own the pins outside a move
    input  wire logic [7:0]  latch_ad,
    input  wire logic        latch_ad_drive_n,
    input  wire logic [7:0]  latch_ah,
    input  wire logic        latch_ale,
    // Interface pins
    input  wire logic [7:0]  ad_in,
    output logic      [7:0]  ad_out,
    output logic             ad_drive_n,
    output logic      [7:0]  ah_out,
    output logic             ale,
    output logic             rd_n,
    output logic             wr_n,
    output logic             pin_claim
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] high_byte(
        input logic [1:0]  route,
        input logic        is_short,
        input logic [15:0] addr,
        input logic [7:0]  page,
        input logic [7:0]  port_hi
    );
        if (!is_short) begin
            high_byte = addr[15:8];
        end else if (route == emifc_pkg::ROUTE_SPLIT_LATCH) begin
            high_byte = port_hi;
        end else begin
            high_byte = page;
        end
    endfunction

    function automatic logic goes_offchip(
        input logic [1:0]  route,
        input logic [15:0] addr
    );
        case (route)
            emifc_pkg::ROUTE_INTERNAL: goes_offchip = 1'b0;
            emifc_pkg::ROUTE_EXTERNAL: goes_offchip = 1'b1;
            default: goes_offchip = (addr >= emifc_pkg::ONCHIP_LIMIT);
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] page_reg;
    logic [7:0] page_next;
    logic [3:0] cfg_reg;
    logic [3:0] cfg_next;
    logic [7:0] sfr_rdata_reg;
    logic [7:0] sfr_rdata_next;
    logic [1:0] route;
    logic [1:0] pulse_sel;

    assign route     = cfg_reg[emifc_pkg::ROUTE_LSB +: 2];
    assign pulse_sel = cfg_reg[emifc_pkg::PULSE_LSB +: 2];

    always_comb begin
        page_next      = page_reg;
        cfg_next       = cfg_reg;
        sfr_rdata_next = sfr_rdata_reg;
        if (sfr_wr && sfr_addr == emifc_pkg::PAGE_SEL_ADDR) begin
            page_next = sfr_wdata;
        end
        if (sfr_wr && sfr_addr == emifc_pkg::CFG_ADDR) begin
            cfg_next = sfr_wdata[3:0];
        end
        if (sfr_rd) begin
            case (sfr_addr)
                emifc_pkg::PAGE_SEL_ADDR: sfr_rdata_next = page_reg;
                emifc_pkg::CFG_ADDR:      sfr_rdata_next = {4'h0, cfg_reg};
                default:                  sfr_rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            page_reg      <= emifc_pkg::PAGE_RESET;
            cfg_reg       <= emifc_pkg::CFG_RESET;
            sfr_rdata_reg <= 8'h00;
        end else begin
            page_reg      <= page_next;
            cfg_reg       <= cfg_next;
            sfr_rdata_reg <= sfr_rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // Access engine
    // ------------------------------------------------------------------
    emifc_pkg::emifc_state_t state_reg;
    emifc_pkg::emifc_state_t state_next;
    logic        write_reg,  write_next;
    logic [7:0]  lo_reg,     lo_next;
    logic [7:0]  hi_reg,     hi_next;
    logic [7:0]  wdata_reg,  wdata_next;
    logic [7:0]  rdata_reg,  rdata_next;
    logic        done_reg,   done_next;
    logic        int_reg,    int_next;
    logic [10:0] int_addr_reg, int_addr_next;
    logic [7:0]  ad_reg,     ad_next;
    logic        drv_n_reg,  drv_n_next;
    logic [7:0]  ah_reg,     ah_next;
    logic        ale_reg,    ale_next;
    logic        rd_n_reg,   rd_n_next;
    logic        wr_n_reg,   wr_n_next;
    logic        claim_reg,  claim_next;
    logic        busy_reg,   busy_next;
    logic        t_load;
    logic [2:0]  t_val;
    logic        t_expired;
    logic        accept;
    logic [7:0]  eff_hi;

    assign accept = req_valid && (state_reg == emifc_pkg::ST_IDLE);
    assign eff_hi = high_byte(route, req_short, req_addr, page_reg,
                              latch_ah);

    emifc_phase_timer u_timer (
        .clk      (clk),
        .rst_n    (rst_sync_reg),
        .load     (t_load),
        .load_val (t_val),
        .expired  (t_expired)
    );

    always_comb begin
        state_next    = state_reg;
        write_next    = write_reg;
        lo_next       = lo_reg;
        hi_next       = hi_reg;
        wdata_next    = wdata_reg;
        rdata_next    = rdata_reg;
        done_next     = 1'b0;
        int_next      = 1'b0;
        int_addr_next = int_addr_reg;
        t_load        = 1'b0;
        t_val         = {1'b0, pulse_sel};
        case (state_reg)
            emifc_pkg::ST_IDLE: begin
                if (accept) begin
                    write_next = req_write;
                    lo_next    = req_addr[7:0];
                    hi_next    = eff_hi;
                    wdata_next = req_wdata;
                    if (goes_offchip(route, {eff_hi, req_addr[7:0]})) begin
                        state_next = emifc_pkg::ST_ADDR;
                        t_load     = 1'b1;
                    end else begin
                        int_next      = 1'b1;
                        done_next     = 1'b1;
                        int_addr_next = {eff_hi[2:0], req_addr[7:0]};
                    end
                end
            end
            emifc_pkg::ST_ADDR: begin
                if (t_expired) begin
                    state_next = emifc_pkg::ST_LATCH;
                    t_load     = 1'b1;
                end
            end
            emifc_pkg::ST_LATCH: begin
                if (t_expired) begin
                    state_next = emifc_pkg::ST_STROBE;
                    t_load     = 1'b1;
                    t_val      = emifc_pkg::STROBE_CYCLES - 3'h1;
                end
            end
            emifc_pkg::ST_STROBE: begin
                if (t_expired) begin
                    state_next = emifc_pkg::ST_IDLE;
                    done_next  = 1'b1;
                    if (!write_reg) begin
                        rdata_next = ad_in;
                    end
                end
            end
            default: state_next = emifc_pkg::ST_IDLE;
        endcase
    end

    // Pins follow the next state so they line up with state_reg.
    // Only levels and enables are driven; pin output mode is untouched.
    always_comb begin
        busy_next  = (state_next != emifc_pkg::ST_IDLE);
        ad_next    = latch_ad;
        drv_n_next = latch_ad_drive_n;
        ah_next    = latch_ah;
        ale_next   = latch_ale;
        rd_n_next  = 1'b1;
        wr_n_next  = 1'b1;
        claim_next = 1'b0;
        case (state_next)
            emifc_pkg::ST_ADDR: begin
                ad_next    = lo_next;
                drv_n_next = 1'b0;
                ah_next    = hi_next;
                ale_next   = 1'b1;
                claim_next = 1'b1;
            end
            emifc_pkg::ST_LATCH: begin
                ad_next    = lo_reg;
                drv_n_next = 1'b0;
                ah_next    = hi_reg;
                ale_next   = 1'b0;
                claim_next = 1'b1;
            end
            emifc_pkg::ST_STROBE: begin
                ad_next    = wdata_reg;
                drv_n_next = !write_reg;
                ah_next    = hi_reg;
                ale_next   = 1'b0;
                rd_n_next  = write_reg;
                wr_n_next  = !write_reg;
                claim_next = 1'b1;
            end
            default: ;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg    <= emifc_pkg::ST_IDLE;
            write_reg    <= 1'b0;
            lo_reg       <= 8'h00;
            hi_reg       <= 8'h00;
            wdata_reg    <= 8'h00;
            rdata_reg    <= 8'h00;
            done_reg     <= 1'b0;
            int_reg      <= 1'b0;
            int_addr_reg <= 11'h000;
            ad_reg       <= 8'hff;
            drv_n_reg    <= 1'b1;
            ah_reg       <= 8'hff;
            ale_reg      <= 1'b0;
            rd_n_reg     <= 1'b1;
            wr_n_reg     <= 1'b1;
            claim_reg    <= 1'b0;
            busy_reg     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            write_reg    <= write_next;
            lo_reg       <= lo_next;
            hi_reg       <= hi_next;
            wdata_reg    <= wdata_next;
            rdata_reg    <= rdata_next;
            done_reg     <= done_next;
            int_reg      <= int_next;
            int_addr_reg <= int_addr_next;
            ad_reg       <= ad_next;
            drv_n_reg    <= drv_n_next;
            ah_reg       <= ah_next;
            ale_reg      <= ale_next;
            rd_n_reg     <= rd_n_next;
            wr_n_reg     <= wr_n_next;
            claim_reg    <= claim_next;
            busy_reg     <= busy_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign sfr_rdata  = sfr_rdata_reg;
    assign busy       = busy_reg;
    assign done       = done_reg;
    assign rdata      = rdata_reg;
    assign int_access = int_reg;
    assign int_addr   = int_addr_reg;
    assign ad_out     = ad_reg;
    assign ad_drive_n = drv_n_reg;
    assign ah_out     = ah_reg;
    assign ale        = ale_reg;
    assign rd_n       = rd_n_reg;
    assign wr_n       = wr_n_reg;
    assign pin_claim  = claim_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [2:0] ale_hi_cnt;

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            ale_hi_cnt <= 3'h0;
        end else if (state_reg == emifc_pkg::ST_ADDR) begin
            ale_hi_cnt <= ale_hi_cnt + 3'h1;
        end else begin
            ale_hi_cnt <= 3'h0;
        end
    end

    a_strobes_idle: assert property (@(posedge clk) disable iff (!rst_sync_reg)
        (state_reg == emifc_pkg::ST_IDLE) |-> (rd_n_reg && wr_n_reg))
        else $error("strobe asserted outside an external move");

    a_claim_only_move: assert property (@(posedge clk) disable iff (!rst_sync_reg)
        claim_reg |-> (state_reg != emifc_pkg::ST_IDLE))
        else $error("pins claimed with no move running");

    a_read_released: assert property (@(posedge clk) disable iff (!rst_sync_reg)
        (!rd_n_reg) |-> (drv_n_reg && wr_n_reg))
        else $error("shared bus driven during read");

    a_ale_high_width: assert property (@(posedge clk) disable iff (!rst_sync_reg)
        $fell(ale_reg) && state_reg == emifc_pkg::ST_LATCH
        |-> ale_hi_cnt == {1'b0, pulse_sel} + 3'h1)
        else $error("latch strobe high width wrong");

    a_addr_phase: assert property (@(posedge clk) disable iff (!rst_sync_reg)
        (state_reg == emifc_pkg::ST_ADDR)
        |-> (ale_reg && !drv_n_reg && ad_reg == lo_reg && ah_reg == hi_reg))
        else $error("address phase pins wrong");

    a_page_high: assert property (@(posedge clk) disable iff (!rst_sync_reg)
        accept && req_short && route != emifc_pkg::ROUTE_SPLIT_LATCH
        |=> hi_reg == $past(page_reg))
        else $error("page byte not used as high address");

    a_cfg_readback: assert property (@(posedge clk) disable iff (!rst_sync_reg)
        sfr_rd && sfr_addr == emifc_pkg::CFG_ADDR
        |=> sfr_rdata_reg[7:4] == 4'h0 && sfr_rdata_reg[3:0] == $past(cfg_reg))
        else $error("configuration readback wrong");

    a_internal_route: assert property (@(posedge clk) disable iff (!rst_sync_reg)
        accept && route == emifc_pkg::ROUTE_INTERNAL
        |=> int_reg && done_reg && !claim_reg)
        else $error("internal route went off-chip");

    a_strobe_after_ale: assert property (@(posedge clk) disable iff (!rst_sync_reg)
        $fell(rd_n_reg && wr_n_reg) |-> !ale_reg && $past(!ale_reg))
        else $error("strobe without latch low phase");

endmodule
`default_nettype wire

// ---- verif/emifc_sram_model.sv ----
// Off-chip memory with address latch on the multiplexed bus
`timescale 1ns/100ps
`default_nettype none
module emifc_sram_model (
    // Clock
    input  wire logic       clk,
    // Bus pins from the interface
    input  wire logic [7:0] ad_out,
    input  wire logic       ad_drive_n,
    input  wire logic [7:0] ah_out,
    input  wire logic       ale,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    // Bus level seen by the interface
    output logic      [7:0] ad_in
);
    logic [7:0] mem [0:65535];
    logic [65535:0] filled = '0;
    logic [7:0] lo_q   = 8'h00;
    logic [7:0] last_q = 8'h00;
    logic [15:0] addr;

    assign addr = {ah_out, lo_q};

    // Latch loads ad_out on each rising clock edge while ale is high, holds once it falls
    always @(posedge clk) begin
        if (ale) begin
            lo_q <= ad_out;
        end
        if (!wr_n) begin
            mem[addr] <= ad_out;
            filled[addr] <= 1'b1;
        end
        if (!ad_drive_n || !rd_n) begin
            last_q <= ad_in;
        end
    end

    // Released bus shows the inverse of its last level
    always @* begin
        if (!ad_drive_n) begin
            ad_in = ad_out;
        end else if (!rd_n) begin
            ad_in = filled[addr] ? mem[addr] : ~addr[7:0];
        end else begin
            ad_in = ~last_q;
        end
    end
endmodule
`default_nettype wire

// ---- verif/test_multiplexed_ext_memory_iface.sv ----
// Testbench of the multiplexed external memory interface
`timescale 1ns/100ps
`default_nettype none
module test_multiplexed_ext_memory_iface;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  sfr_addr = 8'h00;
    logic        sfr_wr = 1'b0;
    logic        sfr_rd = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic [7:0]  sfr_rdata;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic        req_short = 1'b0;
    logic [15:0] req_addr = 16'h0000;
    logic [7:0]  req_wdata = 8'h00;
    logic        busy, done, int_access;
    logic [7:0]  rdata, ad_in, ad_out, ah_out;
    logic [10:0] int_addr;
    logic [7:0]  latch_ah = 8'hff;
    logic        ad_drive_n, ale, rd_n, wr_n, pin_claim;
    logic [7:0]  v;
    int          err_count = 0;
    int          checks_done = 0;

    emifc_top dut (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .req_valid(req_valid),
        .req_write(req_write), .req_short(req_short), .req_addr(req_addr),
        .req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata),
        .int_access(int_access), .int_addr(int_addr),
        .latch_ad(8'hff), .latch_ad_drive_n(1'b1),
        .latch_ah(latch_ah),
        .latch_ale(1'b0), .ad_in(ad_in), .ad_out(ad_out),
        .ad_drive_n(ad_drive_n), .ah_out(ah_out), .ale(ale), .rd_n(rd_n),
        .wr_n(wr_n), .pin_claim(pin_claim));

    // Strobe pins reach the memory directly
    emifc_sram_model ext_mem (.clk(clk), .ad_out(ad_out),
        .ad_drive_n(ad_drive_n), .ah_out(ah_out), .ale(ale), .rd_n(rd_n),
        .wr_n(wr_n), .ad_in(ad_in));

    initial begin
        forever #50 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Checking and access tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                       input string msg);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h",
                     $time, msg, seen, exp);
        end
    endtask

    task test_done;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1 d = sfr_rdata;
    endtask

    // One move; ea is the effective address, w the pulse field value
    task automatic mv(input logic wr, input logic sh, input logic [15:0] ea,
                      input logic [7:0] d, input logic ext, input int w);
        int n;
        int ah;
        int al;
        int sl;
        n = 0;
        ah = 0;
        al = 0;
        sl = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_short <= sh;
        req_addr <= sh ? {8'hee, ea[7:0]} : ea;
        req_wdata <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        do begin
            #1 n++;
            if (!pin_claim) begin
                chk({rd_n, wr_n}, 2'b11, "idle strobes");
            end else if (ale) begin
                ah++;
                chk(busy, 1'b1, "busy during move");
                chk(ad_out, ea[7:0], "low address");
                chk(ah_out, ea[15:8], "high address");
            end else if (rd_n && wr_n) begin
                al++;
            end else begin
                sl++;
                chk(ad_drive_n, !wr, "data driver");
                if (!wr_n) chk(ad_out, d, "write data");
            end
            if (!done) @(posedge clk);
        end while (!done && n < 20);
        chk(16'(n), ext ? 16'(2 * w + 5) : 16'h0001, "move length");
        chk(int_access, !ext, "route");
        if (!ext) chk(int_addr, ea[10:0], "on-chip address");
        if (ext) begin
            chk(16'(ah), 16'(w + 1), "latch high time");
            chk(16'(al), 16'(w + 1), "latch low time");
            chk(16'(sl), emifc_pkg::STROBE_CYCLES, "strobe");
            if (!wr) chk(rdata, d, "read data");
        end
        chk(pin_claim, 1'b0, "claim release");
        chk({rd_n, wr_n}, 2'b11, "strobes after move");
        chk(ad_out, 8'hff, "pins back to latch");
        chk(ad_drive_n, 1'b1, "driver back to latch");
        chk(busy, 1'b0, "busy after move");
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(pin_claim, 1'b0, "claim after reset");
        chk({rd_n, wr_n}, 2'b11, "strobes after reset");
        reg_rd(emifc_pkg::PAGE_SEL_ADDR, v);
        chk(v, emifc_pkg::PAGE_RESET, "page reset");
        reg_rd(emifc_pkg::CFG_ADDR, v);
        chk(v, {4'h0, emifc_pkg::CFG_RESET}, "config reset");
        reg_rd(8'h55, v);
        chk(v, 8'h00, "unmapped read");
        reg_wr(emifc_pkg::CFG_ADDR, 8'hef);
        reg_rd(emifc_pkg::CFG_ADDR, v);
        chk(v, 8'h0f, "config top bits");
        reg_wr(emifc_pkg::PAGE_SEL_ADDR, 8'h5a);
        reg_rd(emifc_pkg::PAGE_SEL_ADDR, v);
        chk(v, 8'h5a, "page write");
        // Off-chip only, every latch pulse width, write then read back
        for (int w = 0; w < 4; w++) begin
            reg_wr(emifc_pkg::CFG_ADDR, 8'(8'h0c + w));
            mv(1'b1, 1'b0, 16'(16'h1200 + w), 8'(8'ha0 + w), 1'b1, w);
            mv(1'b0, 1'b0, 16'(16'h1200 + w), 8'(8'ha0 + w), 1'b1, w);
        end
        // Split with page register
        reg_wr(emifc_pkg::CFG_ADDR, 8'h09);
        reg_wr(emifc_pkg::PAGE_SEL_ADDR, 8'h12);
        mv(1'b0, 1'b1, 16'h1200, 8'ha0, 1'b1, 1);
        mv(1'b0, 1'b0, 16'h0234, 8'h00, 1'b0, 1);
        reg_wr(emifc_pkg::PAGE_SEL_ADDR, 8'h07);
        mv(1'b0, 1'b1, 16'h07ff, 8'h00, 1'b0, 1);
        // Split with high byte from the port latch
        reg_wr(emifc_pkg::CFG_ADDR, 8'h05);
        reg_wr(emifc_pkg::PAGE_SEL_ADDR, 8'h34);
        latch_ah <= 8'h12;
        repeat (2) @(posedge clk);
        #1 chk(ah_out, 8'h12, "idle high port");
        mv(1'b0, 1'b1, 16'h1201, 8'ha1, 1'b1, 1);
        latch_ah <= 8'hff;
        mv(1'b1, 1'b0, 16'h0800, 8'h3c, 1'b1, 1);
        mv(1'b0, 1'b0, 16'h0800, 8'h3c, 1'b1, 1);
        mv(1'b0, 1'b0, 16'h07ff, 8'h00, 1'b0, 1);
        // On-chip only aliases every address
        reg_wr(emifc_pkg::CFG_ADDR, 8'h00);
        mv(1'b1, 1'b0, 16'h1234, 8'h77, 1'b0, 0);
        test_done;
    end

    initial begin
        #2000000;
        err_count++;
        test_done;
    end
endmodule
`default_nettype wire
